// ==== reset_source_pkg.sv ====
// constants for the reset source controller
package reset_source_pkg;
    // register byte offsets
    localparam logic [7:0] off_soft_reset_key = 8'h00;
    localparam logic [7:0] off_cause_flags = 8'h04;
    localparam logic [7:0] off_level_select = 8'h08;
    localparam logic [7:0] off_watchdog_ctrl = 8'h0c;
    localparam logic [7:0] off_flash_ctrl = 8'h10;
    localparam logic [7:0] off_status = 8'h14;
    // codes and reset values
    localparam logic [7:0] key_nop_a = 8'h55;
    localparam logic [7:0] key_nop_b = 8'haa;
    localparam logic [7:0] level_1v7 = 8'h66;
    localparam logic [7:0] level_1v9 = 8'h55;
    localparam logic [7:0] level_2v55 = 8'h33;
    localparam logic [7:0] level_3v15 = 8'h99;
    localparam logic [7:0] level_3v8 = 8'haa;
    localparam logic [7:0] level_off = 8'hf0;
    localparam logic [7:0] watchdog_ctrl_reset = 8'h53;
    localparam logic [4:0] wd_key_enable = 5'h0a;
    localparam logic [4:0] wd_key_disable = 5'h15;
    localparam logic [7:0] flash_reset_value = 8'h55;
    // cause flag bit positions
    localparam int key_flag_bit = 3;
    localparam int brownout_flag_bit = 2;
    localparam int level_flag_bit = 1;
    localparam int wd_key_flag_bit = 0;
    // status bit positions
    localparam int timeout_bit = 0;
    localparam int powerdown_bit = 1;
    // timing
    localparam int clk_mhz = 50;
    localparam int soft_reset_delay_us = 50;
    localparam int soft_reset_cycles = soft_reset_delay_us * clk_mhz;
    localparam int brownout_qualify_us = 60;
    localparam int brownout_qualify_cycles = brownout_qualify_us * clk_mhz;
    localparam int reset_pulse_cycles = 16;
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;
endpackage : reset_source_pkg

// ==== reset_source_control.sv ====
// reset source controller with axi4-lite registers
// What this block does
// RULE1 - illegal soft key resets after delay
// RULE2 - soft key powers up as 0x55
// RULE3 - key reset sets sticky key flag
// RULE4 - resets restore key except sleep watchdog
// RULE5 - upper four flag bits read zero
// RULE6 - brown-out active except sleep and level off code
// RULE7 - low supply must persist to reset
// RULE8 - brown-out reset keeps level register
// RULE9 - five thresholds plus disable code decode
// RULE10 - illegal level code resets, restores register
// RULE11 - illegal level code sets fault flag
// RULE12 - level register powers up as 0x66
// RULE13 - brown-out reset sets sticky brown-out flag
// RULE14 - writing 0x55 to flash control resets
// RULE15 - run-mode watchdog timeout resets, sets flag
// RULE16 - sleep watchdog timeout clears pc, sp only
// RULE17 - power-on starts at zero, ports high
// RULE18 - illegal watchdog key resets, sets flag
// RULE19 - soft reset delay is a counter
// RULE20 - writing one to flags does nothing
`timescale 1ns/100ps
`default_nettype none
module reset_source_control (
    // clock and reset (aresetn is the power-on reset)
    input wire logic aclk,
    input wire logic aresetn,
    // write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output var logic s_axi_awready,
    // write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output var logic s_axi_wready,
    // write response
    output var logic [1:0] s_axi_bresp,
    output var logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output var logic s_axi_arready,
    // read data
    output var logic [31:0] s_axi_rdata,
    output var logic [1:0] s_axi_rresp,
    output var logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // system inputs
    input wire logic low_supply,
    input wire logic sleep_mode,
    input wire logic watchdog_timeout,
    // reset outputs
    output var logic system_reset,
    output var logic core_pointer_clear,
    output var logic port_preset
);
    typedef enum logic [2:0] {
        st_run = 3'b001,
        st_delay = 3'b010,
        st_reset = 3'b100
    } seq_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [7:0] awaddr;
        logic aw_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_held;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] soft_reset_key;
        logic [3:0] cause;
        logic [7:0] level_select;
        logic [7:0] watchdog_ctrl;
        logic [1:0] status;
        seq_t seq;
        logic [2:0] pending;
        logic wd_pend;
        logic [15:0] delay_cnt;
        logic [15:0] low_cnt;
        logic [4:0] pulse_cnt;
        logic system_reset;
        logic core_pointer_clear;
        logic port_preset;
    } state_t;

    state_t s_reg;
    state_t s_next;

    function automatic logic level_legal(input logic [7:0] code);
        level_legal = (code == reset_source_pkg::level_1v7)
            || (code == reset_source_pkg::level_1v9)
            || (code == reset_source_pkg::level_2v55)
            || (code == reset_source_pkg::level_3v15)
            || (code == reset_source_pkg::level_3v8)
            || (code == reset_source_pkg::level_off); // RULE9
    endfunction : level_legal

    function automatic logic [7:0] merge(input logic [7:0] old,
            input logic [31:0] d, input logic [3:0] be);
        merge = be[0] ? d[7:0] : old;
    endfunction : merge

    logic key_bad;
    logic level_bad;
    logic wd_key_bad;
    logic brownout_on;
    logic brownout_hit;
    logic do_write;
    logic [7:0] wr_val;

    always_comb begin
        s_next = s_reg;
        // soft faults are reached only through the delay counter
        key_bad = (s_reg.soft_reset_key != reset_source_pkg::key_nop_a)
            && (s_reg.soft_reset_key != reset_source_pkg::key_nop_b); // RULE1
        level_bad = !level_legal(s_reg.level_select); // RULE10
        wd_key_bad = (s_reg.watchdog_ctrl[7:3]
            != reset_source_pkg::wd_key_enable)
            && (s_reg.watchdog_ctrl[7:3]
            != reset_source_pkg::wd_key_disable); // RULE18
        brownout_on = (s_reg.level_select != reset_source_pkg::level_off)
            && !sleep_mode; // RULE6
        brownout_hit = brownout_on && low_supply && (s_reg.low_cnt
            >= 16'(reset_source_pkg::brownout_qualify_cycles)); // RULE7
        s_next.system_reset = 1'b0;
        s_next.core_pointer_clear = 1'b0;
        s_next.port_preset = 1'b0;
        // low supply qualification; short dips just restart it
        if (brownout_on && low_supply) begin
            if (!brownout_hit) begin
                s_next.low_cnt = s_reg.low_cnt + 16'h0001; // RULE7
            end
        end else begin
            s_next.low_cnt = 16'h0000;
        end
        // write channel: either order, response after both
        if (s_reg.awready && s_axi_awvalid) begin
            s_next.awready = 1'b0;
            s_next.aw_held = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_reg.wready && s_axi_wvalid) begin
            s_next.wready = 1'b0;
            s_next.w_held = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        do_write = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
        wr_val = 8'h00;
        if (do_write) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = reset_source_pkg::resp_okay;
            case (s_reg.awaddr)
                reset_source_pkg::off_soft_reset_key: begin
                    s_next.soft_reset_key = merge(s_reg.soft_reset_key,
                        s_reg.wdata, s_reg.wstrb);
                end
                reset_source_pkg::off_cause_flags: begin
                    // zeros clear, ones are ignored
                    wr_val = merge(8'hff, s_reg.wdata, s_reg.wstrb);
                    s_next.cause = s_reg.cause & wr_val[3:0]; // RULE20
                end
                reset_source_pkg::off_level_select: begin
                    s_next.level_select = merge(s_reg.level_select,
                        s_reg.wdata, s_reg.wstrb);
                end
                reset_source_pkg::off_watchdog_ctrl: begin
                    s_next.watchdog_ctrl = merge(s_reg.watchdog_ctrl,
                        s_reg.wdata, s_reg.wstrb);
                end
                reset_source_pkg::off_flash_ctrl: begin
                    wr_val = merge(8'h00, s_reg.wdata, s_reg.wstrb);
                    if (wr_val == reset_source_pkg::flash_reset_value) begin
                        s_next.pending[2] = 1'b1; // RULE14
                    end
                end
                reset_source_pkg::off_status: begin
                    // status is read only here
                end
                default: begin
                    s_next.bresp = reset_source_pkg::resp_slverr;
                end
            endcase
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
        end
        // read channel
        if (s_reg.arready && s_axi_arvalid) begin
            s_next.arready = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp = reset_source_pkg::resp_okay;
            case (s_axi_araddr)
                reset_source_pkg::off_soft_reset_key:
                    s_next.rdata = {24'h000000, s_reg.soft_reset_key};
                reset_source_pkg::off_cause_flags:
                    s_next.rdata = {28'h0000000, s_reg.cause}; // RULE5
                reset_source_pkg::off_level_select:
                    s_next.rdata = {24'h000000, s_reg.level_select};
                reset_source_pkg::off_watchdog_ctrl:
                    s_next.rdata = {24'h000000, s_reg.watchdog_ctrl};
                reset_source_pkg::off_flash_ctrl:
                    s_next.rdata = 32'h00000000;
                reset_source_pkg::off_status:
                    s_next.rdata = {30'h00000000, s_reg.status};
                default: begin
                    s_next.rdata = 32'h00000000;
                    s_next.rresp = reset_source_pkg::resp_slverr;
                end
            endcase
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end
        // reset sequencing
        case (s_reg.seq)
            st_run: begin
                if (key_bad || level_bad || wd_key_bad) begin
                    s_next.seq = st_delay;
                    s_next.delay_cnt = 16'h0000;
                    s_next.pending = {s_next.pending[2], level_bad,
                        key_bad};
                    // latched so a key repaired during the delay still flags
                    s_next.wd_pend = wd_key_bad;
                end
                if (s_next.pending[2] || brownout_hit) begin
                    s_next.seq = st_reset;
                    s_next.pulse_cnt = 5'h00;
                end
                if (brownout_hit) begin
                    s_next.cause[reset_source_pkg::brownout_flag_bit] =
                        1'b1; // RULE13
                end
                if (watchdog_timeout) begin
                    s_next.status[reset_source_pkg::timeout_bit] = 1'b1;
                    if (sleep_mode) begin
                        s_next.status[reset_source_pkg::powerdown_bit] =
                            1'b1; // RULE16
                        s_next.core_pointer_clear = 1'b1; // RULE16
                    end else begin
                        s_next.seq = st_reset; // RULE15
                        s_next.pulse_cnt = 5'h00;
                    end
                end
            end
            st_delay: begin
                // delay counted on the system clock
                s_next.delay_cnt = s_reg.delay_cnt + 16'h0001; // RULE19
                if (s_reg.delay_cnt >= 16'(reset_source_pkg::soft_reset_cycles
                        - 1)) begin
                    s_next.seq = st_reset;
                    s_next.pulse_cnt = 5'h00;
                    if (s_reg.pending[0]) begin
                        s_next.cause[reset_source_pkg::key_flag_bit] =
                            1'b1; // RULE3
                    end
                    if (s_reg.pending[1]) begin
                        s_next.cause[reset_source_pkg::level_flag_bit] =
                            1'b1; // RULE11
                        s_next.level_select =
                            reset_source_pkg::level_1v7; // RULE10
                    end
                    if (s_reg.wd_pend) begin
                        s_next.cause[reset_source_pkg::wd_key_flag_bit] =
                            1'b1; // RULE18
                    end
                end
            end
            st_reset: begin
                // full reset: key and watchdog control restored,
                // level register kept unless it faulted
                s_next.system_reset = 1'b1;
                s_next.port_preset = 1'b1;
                s_next.core_pointer_clear = 1'b1;
                s_next.soft_reset_key = reset_source_pkg::key_nop_a; // RULE4
                s_next.watchdog_ctrl = reset_source_pkg::watchdog_ctrl_reset;
                s_next.pending = 3'b000; // RULE8
                s_next.low_cnt = 16'h0000;
                s_next.pulse_cnt = s_reg.pulse_cnt + 5'h01;
                if (s_reg.pulse_cnt == 5'(reset_source_pkg::reset_pulse_cycles
                        - 1)) begin
                    s_next.seq = st_run;
                end
            end
            default: begin
                s_next.seq = st_run;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
            s_reg.soft_reset_key <= reset_source_pkg::key_nop_a; // RULE2
            s_reg.level_select <= reset_source_pkg::level_1v7; // RULE12
            s_reg.watchdog_ctrl <= reset_source_pkg::watchdog_ctrl_reset;
            s_reg.seq <= st_run;
            // power-on: core restarts at address zero, ports as inputs
            s_reg.system_reset <= 1'b1; // RULE17
            s_reg.core_pointer_clear <= 1'b1; // RULE17
            s_reg.port_preset <= 1'b1; // RULE17
        end else begin
            s_reg <= s_next;
        end
    end

    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign system_reset = s_reg.system_reset;
    assign core_pointer_clear = s_reg.core_pointer_clear;
    assign port_preset = s_reg.port_preset;
endmodule : reset_source_control
`default_nettype wire

// ==== reset_source_sva.sv ====
// port assertions for the reset source controller
`timescale 1ns/100ps
`default_nettype none
module reset_source_sva (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // events and reset outputs
    input wire logic sleep_mode,
    input wire logic watchdog_timeout,
    input wire logic system_reset,
    input wire logic core_pointer_clear,
    input wire logic port_preset
);
    // pulse length counter; prev held high in reset so release is no pulse
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic prev_reg;
    always_comb begin
        cnt_next = 5'h00;
        if (system_reset && (cnt_reg != 5'h00 || !prev_reg)) begin
            cnt_next = (cnt_reg == 5'h1f) ? cnt_reg : cnt_reg + 5'h01;
        end
    end
    always_ff @(posedge aclk) begin
        cnt_reg <= aresetn ? cnt_next : 5'h00;
        prev_reg <= aresetn ? system_reset : 1'b1;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_PULSE_LEN: assert property ($fell(system_reset) && cnt_reg != 5'h00
        |-> cnt_reg == 5'h10) else $error("reset pulse not 16 cycles");
    AST_PULSE_HOLD: assert property ($rose(system_reset)
        |=> system_reset[*8]) else $error("reset pulse too short");
    AST_PORTS_HIGH: assert property (system_reset
        |-> port_preset && core_pointer_clear) else $error("ports not preset");
    AST_RUN_TIMEOUT: assert property (watchdog_timeout && !sleep_mode
        && !system_reset |-> ##[1:2] system_reset) else $error("no run reset");
    AST_SLEEP_CLEAR: assert property (watchdog_timeout && sleep_mode
        && !system_reset |-> ##[1:2] core_pointer_clear)
        else $error("no pointer clear");
    AST_SLEEP_PULSE: assert property ($rose(core_pointer_clear)
        && !system_reset |=> !core_pointer_clear || system_reset)
        else $error("sleep clear not one cycle");
    AST_UPPER_ZERO: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
    AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    cover property ($rose(system_reset));
    cover property ($rose(core_pointer_clear) && !system_reset);
    cover property (s_axi_rvalid && s_axi_arvalid == 1'b0);
endmodule : reset_source_sva
bind reset_source_control reset_source_sva u_sva (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .sleep_mode(sleep_mode),
    .watchdog_timeout(watchdog_timeout), .system_reset(system_reset),
    .core_pointer_clear(core_pointer_clear), .port_preset(port_preset));
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the reset source controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, low, slp, wdt, srst, cpc, pp;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rresp_q;
    logic sr_q = 1'b0;
    int mismatches = 0, samples_checked = 0, cycles = 0, rises = 0, r0;
    reset_source_control dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_supply(low),
        .sleep_mode(slp), .watchdog_timeout(wdt), .system_reset(srst),
        .core_pointer_clear(cpc), .port_preset(pp));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // rises counted here since some resets start before the bus write ends
    // sampled on the falling edge, where design outputs have settled
    always @(negedge aclk) begin
        sr_q <= srst;
        if (srst && !sr_q && aresetn) rises <= rises + 1;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic aw_ok, w_ok, done;
        logic [1:0] br;
        done = 1'b0;
        br = 2'b11;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // handshakes sampled mid-cycle, released at the next edge
        while (!done) begin
            @(negedge aclk);
            aw_ok = awready && awvalid;
            w_ok = wready && wvalid;
            done = bvalid;
            br = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        chk({30'h0, br}, 32'h0);
    endtask : wr
    task rdr(input logic [7:0] a);
        logic ar_ok, done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(negedge aclk);
            ar_ok = arready && arvalid;
            done = rvalid;
            rd = rdata;
            rresp_q = rresp;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        chk({8'h00, rd[31:8]}, 32'h0);
    endtask : rdr
    task wait_rst(input int start, input int lo, input int hi);
        int n;
        n = 0;
        while (rises == start && n < hi + 2) begin
            @(posedge aclk);
            n = n + 1;
        end
        chk({31'h0, n >= lo && n <= hi}, 32'h1);
        chk({30'h0, pp, cpc}, 32'h3);
        while (srst) @(negedge aclk);
        repeat (2) @(posedge aclk);
    endtask : wait_rst
    task no_rst(input int n);
        int start;
        start = rises;
        repeat (n) @(posedge aclk);
        chk(rises - start, 32'h0);
    endtask : no_rst
    task t_por();
        rdr(8'h00); chk(rd, 32'h55);
        rdr(8'h08); chk(rd, 32'h66);
        rdr(8'h04); chk(rd, 32'h0);
        rdr(8'h18); chk({30'h0, rresp_q}, 32'h2);
    endtask : t_por
    task t_key();
        wr(8'h00, 8'haa); no_rst(2600);
        r0 = rises; wr(8'h00, 8'h00); wait_rst(r0, 2490, 2505);
        rdr(8'h04); chk(rd, 32'h8);
        rdr(8'h00); chk(rd, 32'h55);
        wr(8'h04, 8'h0f); rdr(8'h04); chk(rd, 32'h8);
        wr(8'h04, 8'h00); rdr(8'h04); chk(rd, 32'h0);
    endtask : t_key
    task t_level();
        automatic logic [7:0] codes [6] = '{8'h66, 8'h55, 8'h33, 8'h99,
            8'haa, 8'hf0};
        foreach (codes[i]) begin
            wr(8'h08, codes[i]); rdr(8'h08); chk(rd, {24'h0, codes[i]});
        end
        no_rst(2600);
        r0 = rises; wr(8'h08, 8'h12); wait_rst(r0, 2490, 2505);
        rdr(8'h04); chk(rd, 32'h2);
        rdr(8'h08); chk(rd, 32'h66);
        wr(8'h04, 8'h00);
    endtask : t_level
    task t_brown();
        wr(8'h08, 8'h33);
        low <= 1'b1; no_rst(2000); low <= 1'b0; no_rst(1100);
        slp <= 1'b1; low <= 1'b1; no_rst(3500); slp <= 1'b0;
        // low stays up: qualification starts once sleep ends
        r0 = rises; wait_rst(r0, 2990, 3010); low <= 1'b0;
        rdr(8'h04); chk(rd, 32'h4);
        rdr(8'h08); chk(rd, 32'h33);
        wr(8'h08, 8'hf0); low <= 1'b1; no_rst(3200); low <= 1'b0;
        wr(8'h04, 8'h00);
    endtask : t_brown
    task t_wd();
        r0 = rises; wr(8'h0c, 8'h00); wait_rst(r0, 2490, 2505);
        rdr(8'h04); chk(rd, 32'h1);
        rdr(8'h0c); chk(rd, 32'h53);
        wr(8'h04, 8'h00);
        r0 = rises; wdt <= 1'b1; @(posedge aclk); wdt <= 1'b0;
        wait_rst(r0, 0, 4);
        rdr(8'h14); chk(rd, 32'h1);
        wr(8'h00, 8'haa); slp <= 1'b1; @(posedge aclk);
        wdt <= 1'b1; @(posedge aclk); wdt <= 1'b0;
        @(negedge aclk); chk({31'h0, cpc}, 32'h1);
        no_rst(20);
        slp <= 1'b0;
        rdr(8'h14); chk(rd, 32'h3);
        rdr(8'h00); chk(rd, 32'haa);
    endtask : t_wd
    task t_flash();
        r0 = rises; wr(8'h10, 8'h55); wait_rst(r0, 0, 20);
        rdr(8'h00); chk(rd, 32'h55);
    endtask : t_flash
    task close_out();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {low, slp, wdt, awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        chk({29'h0, srst, pp, cpc}, 32'h7);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_por(); t_key(); t_level(); t_brown(); t_wd(); t_flash();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
